// File: src/mtb_pkg.sv
// What this block does
// - primary prescaler divides input clock by two to the code; 111 reserved.
// - primary period register is 16-bit read/write, resets to all ones.
// - primary compare holds 13 bits in 15..3; bits 2..0 read zero.
// - one compare count is one counter step; usable step is eight counts.
// - secondary event interrupt enable gates the event; pending flag is read-only.
// - immediate update loads the secondary period at once, else at rollover.
// - sync polarity makes sync input and secondary sync output active low.
// - sync output enable lets the secondary sync output pulse.
// - external sync enable lets the selected source restart the secondary base.
// - secondary base has its own prescaler field with the same encoding.
// - secondary period register is 16-bit read/write, resets to all ones.
// - secondary compare register is separate and resets to zero.
// - secondary compare holds 13 bits in 15..3; bits 2..0 read zero.
package mtb_pkg;
    // byte offsets of the register words
    localparam logic [5:0] OFS_PRI_PERIOD = 6'h00;
    localparam logic [5:0] OFS_PRI_COMPARE = 6'h04;
    localparam logic [5:0] OFS_SEC_CONTROL = 6'h08;
    localparam logic [5:0] OFS_SEC_DIVIDER = 6'h0c;
    localparam logic [5:0] OFS_SEC_PERIOD = 6'h10;
    localparam logic [5:0] OFS_SEC_COMPARE = 6'h14;
    localparam logic [5:0] OFS_PRI_DIVIDER = 6'h18;
    localparam logic [5:0] OFS_ENABLE = 6'h1c;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h20;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h24;
    localparam logic [5:0] OFS_COUNTERS = 6'h28;
    // secondary control field positions, and the compare field position
    localparam int POS_PENDING = 12;
    localparam int POS_IRQ_EN = 11;
    localparam int POS_IMMEDIATE = 10;
    localparam int POS_POLARITY = 9;
    localparam int POS_SYNC_OEN = 8;
    localparam int POS_EXT_SYNC = 7;
    localparam int POS_SRC = 4;
    localparam int POS_POSTSCALE = 0;
    localparam int POS_CMP = 3;
    // interrupt status bits
    localparam int IRQ_PRI_EVENT = 0;
    localparam int IRQ_SEC_EVENT = 1;
    localparam int IRQ_PRI_ROLL = 2;
    localparam int IRQ_SEC_ROLL = 3;
    localparam int IRQ_SYNC = 4;
    localparam int IRQ_BITS = 5;
    // reset values and the reserved divider code
    localparam logic [15:0] RST_PERIOD = 16'hffff;
    localparam logic [12:0] RST_COMPARE = 13'h0000;
    localparam logic [2:0] RST_DIVIDER = 3'h0;
    localparam logic [2:0] DIV_RESERVED = 3'h7;
    // sync source codes
    localparam logic [2:0] SRC_SYNC_IN1 = 3'h0;
    localparam logic [2:0] SRC_SYNC_IN2 = 3'h1;
    localparam logic [2:0] SRC_PRI_TRIGGER = 3'h2;
    localparam logic [2:0] SRC_PRI_ROLL = 3'h3;

    typedef struct packed {
        logic [5:0] presc;
        logic [15:0] count;
        logic rollover;
        logic match;
    } mtb_base_state_type;
endpackage : mtb_pkg

// File: src/mtb_base_if.sv
`timescale 1ns/1ns
// carries one time base's setup and its events
interface mtb_base_if;
    logic enable;
    logic restart;
    logic [2:0] divider;
    logic [15:0] period;
    logic [15:0] compare;
    logic [15:0] count;
    logic rollover;
    logic match;
    modport ctrl (output enable, output restart, output divider, output period, output compare,
        input count, input rollover, input match);
    modport base (input enable, input restart, input divider, input period, input compare,
        output count, output rollover, output match);
endinterface : mtb_base_if

// File: src/mtb_time_base.sv
`timescale 1ns/1ns
module mtb_time_base
    import mtb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    mtb_base_if.base bus
);
    mtb_base_state_type state;
    mtb_base_state_type next_state;
    logic [6:0] one_hot;
    logic [5:0] mask;
    logic tick;

    // prescaler tick: low bits of the free counter all ones
    always_comb
    begin
        one_hot = 7'h01 << bus.divider;
        mask = 6'(one_hot - 7'h01);
        tick = (bus.divider != DIV_RESERVED) && ((state.presc & mask) == mask);
    end

    // counter, rollover and compare match
    always_comb
    begin
        next_state = state;
        next_state.rollover = 1'b0;
        next_state.match = 1'b0;
        if (!bus.enable)
        begin
            next_state.presc = 6'h00;
            next_state.count = 16'h0000;
        end
        else if (bus.restart)
        begin
            next_state.presc = 6'h00; // restart realigns the prescaler too
            next_state.count = 16'h0000;
        end
        else
        begin
            next_state.presc = 6'(state.presc + 6'h01);
            if (tick)
            begin
                next_state.match = (state.count == bus.compare);
                if (state.count >= bus.period)
                begin
                    next_state.count = 16'h0000;
                    next_state.rollover = 1'b1;
                end
                else
                begin
                    next_state.count = 16'(state.count + 16'h0001);
                end
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            state <= '0;
        else
            state <= next_state;
    end

    assign bus.count = state.count;
    assign bus.rollover = state.rollover;
    assign bus.match = state.match;
endmodule : mtb_time_base

// File: src/mtb_top.sv
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
module mtb_top
    import mtb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [1:0] i_sync_input,
    output logic o_secondary_sync_out,
    output logic o_primary_trigger,
    output logic o_secondary_trigger,
    output logic o_irq
);
    typedef struct packed {
        logic module_enable;
        logic [2:0] input_clock_divider;
        logic [15:0] primary_period;
        logic [15:0] primary_active_period;
        logic [12:0] primary_event_compare;
        logic event_irq_enable;
        logic immediate_period_update;
        logic sync_polarity;
        logic sync_out_enable;
        logic external_sync_enable;
        logic [2:0] sync_source_select;
        logic [3:0] trigger_postscale;
        logic [2:0] secondary_clock_divider;
        logic [15:0] secondary_period;
        logic [15:0] secondary_active_period;
        logic [12:0] secondary_event_compare;
        logic [3:0] post_count;
        logic [1:0] sync_s1;
        logic [1:0] sync_s2;
        logic [1:0] sync_s3;
        logic [1:0] sync_level;
        logic sec_restart;
        logic [IRQ_BITS-1:0] irq_status;
        logic [IRQ_BITS-1:0] irq_mask;
        logic served;
        logic [31:0] readdata;
        logic primary_trigger;
        logic secondary_trigger;
        logic sync_out;
        logic irq;
    } mtb_top_state_type;

    mtb_top_state_type state;
    mtb_top_state_type next_state;
    mtb_base_if pri_if ();
    mtb_base_if sec_if ();

    logic access;
    logic do_write;
    logic [15:0] wr_word;
    logic [15:0] wr_mask;
    logic [1:0] sync_edge;
    logic sync_event;
    logic sec_trigger_fire;
    logic [IRQ_BITS-1:0] irq_set;
    logic [IRQ_BITS-1:0] irq_clear;
    logic [15:0] sec_control_word;

    // primary and secondary counters share one implementation
    mtb_time_base u_primary (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .bus(pri_if.base)
    );

    mtb_time_base u_secondary (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .bus(sec_if.base)
    );

    // time base setup; compare low bits are always zero
    always_comb
    begin
        pri_if.enable = state.module_enable;
        pri_if.restart = 1'b0;
        pri_if.divider = state.input_clock_divider;
        pri_if.period = state.primary_active_period;
        pri_if.compare = {state.primary_event_compare, 3'b000};
        sec_if.enable = state.module_enable;
        sec_if.restart = state.sec_restart;
        sec_if.divider = state.secondary_clock_divider;
        sec_if.period = state.secondary_active_period;
        sec_if.compare = {state.secondary_event_compare, 3'b000};
    end

    // bus slave: first cycle waits and latches read data, second completes
    always_comb
    begin
        access = i_avs_read || i_avs_write;
        do_write = i_avs_write && state.served;
        wr_word = i_avs_writedata[15:0];
        wr_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    end

    // secondary control word as software sees it
    always_comb
    begin
        sec_control_word = 16'h0000;
        sec_control_word[POS_PENDING] = state.irq_status[IRQ_SEC_EVENT];
        sec_control_word[POS_IRQ_EN] = state.event_irq_enable;
        sec_control_word[POS_IMMEDIATE] = state.immediate_period_update;
        sec_control_word[POS_POLARITY] = state.sync_polarity;
        sec_control_word[POS_SYNC_OEN] = state.sync_out_enable;
        sec_control_word[POS_EXT_SYNC] = state.external_sync_enable;
        sec_control_word[POS_SRC+:3] = state.sync_source_select;
        sec_control_word[POS_POSTSCALE+:4] = state.trigger_postscale;
    end

    // a sync input edge counts once the second and third stages agree
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            sync_edge[i] = (state.sync_s2[i] == state.sync_s3[i]) && (state.sync_s3[i] != state.sync_level[i])
                && (state.sync_s3[i] == !state.sync_polarity);
        end
    end

    // restart source choice; reserved codes never restart
    always_comb
    begin
        case (state.sync_source_select)
            SRC_SYNC_IN1: sync_event = sync_edge[0];
            SRC_SYNC_IN2: sync_event = sync_edge[1];
            SRC_PRI_TRIGGER: sync_event = pri_if.match;
            SRC_PRI_ROLL: sync_event = pri_if.rollover;
            default: sync_event = 1'b0;
        endcase
    end

    // postscaled trigger from secondary compare matches
    always_comb
    begin
        sec_trigger_fire = sec_if.match && (state.post_count == state.trigger_postscale);
    end

    // interrupt events; secondary event only when its enable is set
    always_comb
    begin
        irq_set = '0;
        irq_set[IRQ_PRI_EVENT] = pri_if.match;
        irq_set[IRQ_SEC_EVENT] = sec_trigger_fire && state.event_irq_enable;
        irq_set[IRQ_PRI_ROLL] = pri_if.rollover;
        irq_set[IRQ_SEC_ROLL] = sec_if.rollover;
        irq_set[IRQ_SYNC] = state.sec_restart;
        irq_clear = '0;
        if (do_write && i_avs_address == OFS_IRQ_STATUS && i_avs_byteenable[0])
            irq_clear = i_avs_writedata[IRQ_BITS-1:0];
    end

    // next state of everything
    always_comb
    begin
        next_state = state;
        // synchronisers; only the second stage reads the first
        next_state.sync_s1 = i_sync_input;
        next_state.sync_s2 = state.sync_s1;
        next_state.sync_s3 = state.sync_s2;
        for (int i = 0; i < 2; i++)
        begin
            if (state.sync_s2[i] == state.sync_s3[i])
                next_state.sync_level[i] = state.sync_s3[i];
        end
        // restart lands one cycle after the source event
        next_state.sec_restart = state.module_enable && state.external_sync_enable && sync_event;

        // postscale counter
        if (!state.module_enable || state.sec_restart)
            next_state.post_count = 4'h0;
        else if (sec_trigger_fire)
            next_state.post_count = 4'h0;
        else if (sec_if.match)
            next_state.post_count = 4'(state.post_count + 4'h1);

        // output pulses
        next_state.primary_trigger = pri_if.match;
        next_state.secondary_trigger = sec_trigger_fire;
        next_state.sync_out = (state.sync_out_enable && sec_if.rollover) ^ state.sync_polarity;

        // period shadows move to the active copies at a cycle boundary or while stopped
        if (!state.module_enable || pri_if.rollover)
            next_state.primary_active_period = state.primary_period;
        if (!state.module_enable || sec_if.rollover)
            next_state.secondary_active_period = state.secondary_period;

        // interrupt status: set wins over a write-one clear
        next_state.irq_status = (state.irq_status & ~irq_clear) | irq_set;
        next_state.irq = |(next_state.irq_status & state.irq_mask);

        // bus handshake
        next_state.served = access && !state.served;
        if (access && !state.served)
        begin
            next_state.readdata = 32'h0000_0000; // unmapped reads give zero
            if (i_avs_read)
            begin
                case (i_avs_address)
                    OFS_PRI_PERIOD: next_state.readdata = {16'h0000, state.primary_period};
                    OFS_PRI_COMPARE: next_state.readdata = {16'h0000, state.primary_event_compare, 3'b000};
                    OFS_SEC_CONTROL: next_state.readdata = {16'h0000, sec_control_word};
                    OFS_SEC_DIVIDER: next_state.readdata = {29'h0000_0000, state.secondary_clock_divider};
                    OFS_SEC_PERIOD: next_state.readdata = {16'h0000, state.secondary_period};
                    OFS_SEC_COMPARE: next_state.readdata = {16'h0000, state.secondary_event_compare, 3'b000};
                    OFS_PRI_DIVIDER: next_state.readdata = {29'h0000_0000, state.input_clock_divider};
                    OFS_ENABLE: next_state.readdata = {31'h0000_0000, state.module_enable};
                    OFS_IRQ_STATUS: next_state.readdata = {27'h0000_0000, state.irq_status};
                    OFS_IRQ_MASK: next_state.readdata = {27'h0000_0000, state.irq_mask};
                    OFS_COUNTERS: next_state.readdata = {sec_if.count, pri_if.count};
                    default: next_state.readdata = 32'h0000_0000;
                endcase
            end
        end

        // register writes; prescaler changes while running are the user's risk
        if (do_write)
        begin
            case (i_avs_address)
                OFS_PRI_PERIOD:
                begin
                    next_state.primary_period = (state.primary_period & ~wr_mask) | (wr_word & wr_mask);
                end
                OFS_PRI_COMPARE:
                begin
                    next_state.primary_event_compare = 13'(((
                        {state.primary_event_compare, 3'b000} & ~wr_mask) | (wr_word & wr_mask)) >> POS_CMP);
                end
                OFS_SEC_CONTROL:
                begin
                    if (i_avs_byteenable[1])
                    begin
                        next_state.event_irq_enable = wr_word[POS_IRQ_EN];
                        next_state.immediate_period_update = wr_word[POS_IMMEDIATE];
                        next_state.sync_polarity = wr_word[POS_POLARITY];
                        next_state.sync_out_enable = wr_word[POS_SYNC_OEN];
                    end
                    if (i_avs_byteenable[0])
                    begin
                        next_state.external_sync_enable = wr_word[POS_EXT_SYNC];
                        next_state.sync_source_select = wr_word[POS_SRC+:3];
                        next_state.trigger_postscale = wr_word[POS_POSTSCALE+:4];
                    end
                end
                OFS_SEC_DIVIDER:
                begin
                    if (i_avs_byteenable[0])
                        next_state.secondary_clock_divider = wr_word[2:0];
                end
                OFS_SEC_PERIOD:
                begin
                    next_state.secondary_period = (state.secondary_period & ~wr_mask) | (wr_word & wr_mask);
                    if (state.immediate_period_update)
                        next_state.secondary_active_period = next_state.secondary_period;
                end
                OFS_SEC_COMPARE:
                begin
                    next_state.secondary_event_compare = 13'(((
                        {state.secondary_event_compare, 3'b000} & ~wr_mask) | (wr_word & wr_mask)) >> POS_CMP);
                end
                OFS_PRI_DIVIDER:
                begin
                    if (i_avs_byteenable[0])
                        next_state.input_clock_divider = wr_word[2:0];
                end
                OFS_ENABLE:
                begin
                    if (i_avs_byteenable[0])
                        next_state.module_enable = wr_word[0];
                end
                OFS_IRQ_MASK:
                begin
                    if (i_avs_byteenable[0])
                        next_state.irq_mask = wr_word[IRQ_BITS-1:0];
                end
                default:
                begin
                    next_state.served = 1'b0; // unmapped writes are dropped
                end
            endcase
        end
    end

    // one register for all state
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            state <= '0;
            state.input_clock_divider <= RST_DIVIDER;
            state.secondary_clock_divider <= RST_DIVIDER;
            state.primary_period <= RST_PERIOD;
            state.primary_active_period <= RST_PERIOD;
            state.secondary_period <= RST_PERIOD;
            state.secondary_active_period <= RST_PERIOD;
            state.primary_event_compare <= RST_COMPARE;
            state.secondary_event_compare <= RST_COMPARE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // bus answer and outputs
    assign o_avs_waitrequest = access && !state.served;
    assign o_avs_readdata = state.readdata;
    assign o_primary_trigger = state.primary_trigger;
    assign o_secondary_trigger = state.secondary_trigger;
    assign o_secondary_sync_out = state.sync_out;
    assign o_irq = state.irq;
endmodule : mtb_top

// File: tb/mtb_sync_src.sv
`timescale 1ns/1ns
// far-side sync source; a fire request becomes an active window on that pin
module mtb_sync_src
    import mtb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic [1:0] i_fire,
    input wire logic [3:0] i_len,
    input wire logic i_pol,
    output logic [1:0] o_sync
);
    logic [3:0] hold [2] = '{4'h0, 4'h0};
    // window length is set by the bench, so a short or a slow pulse can be made
    always_ff @(posedge i_core_clk)
    begin
        for (int k = 0; k < 2; k++)
            hold[k] <= i_fire[k] ? i_len : (hold[k] != 4'h0 ? hold[k] - 4'h1 : 4'h0);
    end
    // idle level follows polarity, active level is its inverse
    assign o_sync = {hold[1] != 4'h0, hold[0] != 4'h0} ^ {2{i_pol}};
endmodule : mtb_sync_src

// File: tb/mtb_top_chk.sv
`timescale 1ns/1ns
module mtb_top_chk
    import mtb_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [1:0] i_sync_input,
    input wire logic o_secondary_sync_out,
    input wire logic o_primary_trigger,
    input wire logic o_secondary_trigger,
    input wire logic o_irq
);
    // one domain, so clock and reset are stated once
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    logic rd_ok;
    // read data is only meaningful in the answer cycle
    assign rd_ok = i_avs_read && !o_avs_waitrequest;
    property p_wait_idle; !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest; endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
    property p_wait_once; $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest; endproperty
    a_wait_once: assert property (p_wait_once) else $error("not one wait cycle");
    property p_pcmp_rd; rd_ok && i_avs_address == OFS_PRI_COMPARE |-> o_avs_readdata[2:0] == 3'h0; endproperty
    a_pcmp_rd: assert property (p_pcmp_rd) else $error("primary compare low bits set");
    property p_scmp_rd; rd_ok && i_avs_address == OFS_SEC_COMPARE |-> o_avs_readdata[2:0] == 3'h0; endproperty
    a_scmp_rd: assert property (p_scmp_rd) else $error("secondary compare low bits set");
    property p_div_rd; rd_ok && i_avs_address == OFS_PRI_DIVIDER |-> o_avs_readdata[31:3] == 29'h0; endproperty
    a_div_rd: assert property (p_div_rd) else $error("divider upper bits set");
    property p_ctl_rd; rd_ok && i_avs_address == OFS_SEC_CONTROL |-> o_avs_readdata[31:13] == 19'h0; endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control upper bits set");
    property p_ptrig; o_primary_trigger |=> !o_primary_trigger; endproperty
    a_ptrig: assert property (p_ptrig) else $error("primary trigger too long");
    property p_strig; o_secondary_trigger |=> !o_secondary_trigger; endproperty
    a_strig: assert property (p_strig) else $error("secondary trigger too long");
    c_irq: cover property ($rose(o_irq));
    c_sync: cover property ($changed(o_secondary_sync_out));
    c_strig: cover property ($rose(o_secondary_trigger));
endmodule : mtb_top_chk
bind mtb_top mtb_top_chk mtb_top_chk_inst (.i_core_clk, .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_sync_input,
    .o_secondary_sync_out, .o_primary_trigger, .o_secondary_trigger, .o_irq);

// File: tb/mtb_top_tb.sv
`timescale 1ns/1ns
module mtb_top_tb
    import mtb_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic re = 1'b0;
    logic we = 1'b0;
    logic pol = 1'b0;
    logic [5:0] ad = 6'h00;
    logic [31:0] wd = 32'h0;
    logic [1:0] fire = 2'h0;
    logic [1:0] sync;
    logic [31:0] rdat, v;
    logic wrq, so, pt, st, irq;
    logic [3:0] obs;
    int n_fail = 0;
    int num_checks = 0;
    int n, c;
    bit hit;
    assign obs = {irq, so, st, pt};
    // 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end
    mtb_top mtb_top_inst (.i_core_clk(clk), .i_nrst(nrst), .i_avs_address(ad), .i_avs_read(re), .i_avs_write(we),
        .i_avs_writedata(wd), .i_avs_byteenable(4'h3), .o_avs_readdata(rdat), .o_avs_waitrequest(wrq),
        .i_sync_input(sync), .o_secondary_sync_out(so), .o_primary_trigger(pt), .o_secondary_trigger(st), .o_irq(irq));
    mtb_sync_src mtb_sync_src_inst (.i_core_clk(clk), .i_fire(fire), .i_len(4'h6), .i_pol(pol), .o_sync(sync));
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        n_fail += int'(g !== e);
    endtask : chk
    // one bus cycle, request held until waitrequest is sampled low
    task automatic xfer(input bit w, input logic [5:0] a, input logic [15:0] d);
        int t;
        t = 0;
        @(posedge clk);
        ad <= a;
        wd <= {16'h0, d};
        we <= w;
        re <= !w;
        do @(posedge clk) t++; while (wrq !== 1'b0 && t < 20);
        v = rdat;
        we <= 1'b0;
        re <= 1'b0;
        n_fail += int'(t >= 20);
        if (t >= 20)
            give_verdict();
    endtask : xfer
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
        xfer(1'b0, a, 16'h0);
        chk(nm, e, v);
    endtask : rdc
    // setup changes only while the bases are stopped
    task automatic cfg(input logic [5:0] a, input logic [15:0] d);
        wr(OFS_ENABLE, 16'h0);
        wr(a, d);
        wr(OFS_ENABLE, 16'h1);
    endtask : cfg
    // bounded wait for a level; the miss is judged by the caller
    task automatic waitv(input int s, input logic l, input int b);
        c = 0;
        do @(posedge clk) c++; while (obs[s] !== l && c < b);
        hit = (obs[s] === l);
    endtask : waitv
    // cycles between two pulses, zero when the second never comes
    task automatic meas(input int s, input int b);
        n = 0;
        waitv(s, 1'b1, b);
        if (hit)
            waitv(s, 1'b0, 2);
        if (hit)
            waitv(s, 1'b1, b);
        if (hit)
            n = c + 1;
    endtask : meas
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int o = 0; o < 48; o += 4)
            rdc("reset value", 6'(o), (o == 0 || o == 16) ? 32'hffff : 32'h0);
        wr(OFS_PRI_COMPARE, 16'h00ff);
        rdc("pri compare", OFS_PRI_COMPARE, 32'h00f8);
        wr(OFS_SEC_COMPARE, 16'hffff);
        rdc("sec compare", OFS_SEC_COMPARE, 32'hfff8);
        wr(6'h2c, 16'h1234);
        rdc("unmapped", 6'h2c, 32'h0);
        // shortest legal periods, compare count eight
        wr(OFS_PRI_PERIOD, 16'h0010);
        wr(OFS_SEC_PERIOD, 16'h0010);
        wr(OFS_PRI_COMPARE, 16'h0008);
        wr(OFS_SEC_COMPARE, 16'h0008);
        rdc("sec period", OFS_SEC_PERIOD, 32'h0010);
        for (int d = 0; d < 7; d++)
        begin
            cfg(OFS_PRI_DIVIDER, 16'(d));
            meas(0, 3000);
            chk("pri trigger spacing", 32'(17 << d), 32'(n));
        end
        for (int i = 0; i < 2; i++)
        begin
            cfg(OFS_SEC_DIVIDER, 16'(i));
            cfg(OFS_SEC_CONTROL, 16'(i * 15));
            meas(1, 3000);
            chk("sec trigger spacing", 32'(17 * (i * 15 + 1) << i), 32'(n));
        end
        // secondary event interrupt: raise, mask, then suppress and clear
        cfg(OFS_SEC_DIVIDER, 16'h0);
        wr(OFS_IRQ_MASK, 16'h0002);
        cfg(OFS_SEC_CONTROL, 16'h0800);
        waitv(3, 1'b1, 100);
        chk("irq raised", 32'h1, 32'(hit));
        rdc("pending flag", OFS_SEC_CONTROL, 32'h1800);
        wr(OFS_IRQ_MASK, 16'h0);
        waitv(3, 1'b0, 5);
        chk("irq masked", 32'h1, 32'(hit));
        cfg(OFS_SEC_CONTROL, 16'h0);
        wr(OFS_IRQ_STATUS, 16'h001f);
        repeat (60) @(posedge clk);
        rdc("pending clear", OFS_SEC_CONTROL, 32'h0);
        // restart from the first pin active high and the second pin active low, obeyed only when enabled
        wr(OFS_IRQ_MASK, 16'h0010);
        for (int k = 0; k < 4; k++)
        begin
            pol <= k[1];
            cfg(OFS_SEC_CONTROL, (16'(k[1]) << 9) | (16'(k[1]) << 4) | (16'(k[0]) << 7));
            wr(OFS_IRQ_STATUS, 16'h001f);
            fire <= 2'(1 << k[1]);
            @(posedge clk);
            fire <= 2'h0;
            waitv(3, 1'b1, 20);
            chk("sync restart", 32'(k[0]), 32'(hit));
        end
        // sync output pulses per rollover when enabled, rests at polarity level when not
        pol <= 1'b0;
        cfg(OFS_SEC_CONTROL, 16'h0100);
        meas(2, 200);
        chk("sync out spacing", 32'd17, 32'(n));
        cfg(OFS_SEC_CONTROL, 16'h0200);
        waitv(2, 1'b0, 40);
        chk("sync out idle", 32'h0, 32'(hit));
        // period shortened while running: immediate takes effect, deferred waits for rollover
        for (int m = 1; m >= 0; m--)
        begin
            wr(OFS_ENABLE, 16'h0);
            wr(OFS_SEC_PERIOD, 16'hfff8);
            wr(OFS_SEC_CONTROL, 16'(m << 10));
            wr(OFS_ENABLE, 16'h1);
            wr(OFS_SEC_PERIOD, 16'h0010);
            meas(1, 300);
            chk("period update", 32'(m * 17), 32'(n));
        end
        give_verdict();
    end
endmodule : mtb_top_tb
